// *** adc_cfg_pkg.sv ***
/*
  Constants shared by the gain, chop and detect register bank.
  Assumes a 32-bit APB bus with 16-bit registers in the low half of each word.
*/
package adc_cfg_pkg;

  // ----------------------------------------------------------------
  // Bus and register widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int GAIN_W = 3;
  localparam int DLY_W = 4;
  localparam int CNT_W = 17;
  localparam int NCH = 6;

  // ----------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_GAIN_SELECT_CH0_CH3 = 6'h04;
  localparam logic [5:0] IDX_GAIN_SELECT_CH4_CH5 = 6'h05;
  localparam logic [5:0] IDX_CFG = 6'h06;
  localparam logic [5:0] IDX_STATUS = 6'h20;
  localparam logic [ADDR_W-1:0] ADDR_GAIN_SELECT_CH0_CH3 = {IDX_GAIN_SELECT_CH0_CH3, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_GAIN_SELECT_CH4_CH5 = {IDX_GAIN_SELECT_CH4_CH5, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CFG = {IDX_CFG, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'b00};

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [REG_W-1:0] RST_GAIN = 16'h0000;
  localparam logic [REG_W-1:0] RST_CFG = 16'h0600;
  localparam int GAIN_LO_LSB = 0;
  localparam int GAIN_HI_LSB = 4;
  localparam int CFG_DLY_LSB = 9;
  localparam int CFG_CHOP_BIT = 8;
  localparam int CFG_ALL_BIT = 7;
  localparam int CFG_NUM_LSB = 4;
  localparam int CFG_LEN_LSB = 1;
  localparam int CFG_DEN_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_TRIG_BIT = 1;

  // Measurement length in conversion periods for each length code.
  localparam logic [11:0] LEN_TABLE [8] = '{
    12'h080, 12'h100, 12'h200, 12'h300, 12'h500, 12'h700, 12'hA00, 12'hE00
  };

endpackage

// *** settle_timer.sv ***
/*
  Chop settling timer: counts 2^(code+1) modulator ticks after a start pulse.
  Assumes tick, start and abort come from logic on the same clock.
*/
`timescale 1ns/1ps
module settle_timer #(
  parameter int CNT_W = 17,
  parameter int CODE_W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic abort,
  input wire logic tick,
  input wire logic [CODE_W-1:0] code,
  output logic busy,
  output logic done
);

  typedef struct packed {
    logic busy;
    logic done;
    logic [CNT_W-1:0] cnt;
  } timer_s;

  timer_s state_reg;
  timer_s state_next;
  logic [CNT_W-1:0] target;

  // The target is the full power of two; the counter is one bit wider
  // than the largest code needs so the top value never wraps.
  assign target = CNT_W'(1) << ({1'b0, code} + 5'd1);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Abort wins over start so that disabling chop always frees the path.
  always_comb begin
    state_next = state_reg;
    state_next.done = 1'b0;
    if (abort) begin
      state_next.busy = 1'b0;
      state_next.cnt = '0;
    end else if (start) begin
      state_next.busy = 1'b1;
      state_next.cnt = '0;
    end else if (state_reg.busy && tick) begin
      if (state_reg.cnt + CNT_W'(1) == target) begin
        state_next.busy = 1'b0;
        state_next.done = 1'b1;
        state_next.cnt = '0;
      end else begin
        state_next.cnt = state_reg.cnt + CNT_W'(1);
      end
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign busy = state_reg.busy;
  assign done = state_reg.done;

endmodule // settle_timer

// *** adc_cfg_regs.sv ***
/*
  APB register bank holding channel gain codes, global chop and
  current-detect configuration, with the chop settling sequencer and
  the detect trigger combiner that these settings steer.
  Assumes mod_tick, chop_start and ch_hit come from logic on pclk.
*/
`timescale 1ns/1ps
// Behaviour
// - Channel-1 gain code lives in bits 6:4, codes select gain 2^n, reset 000b.
// - Channel-0 gain code lives in bits 2:0 of the same register, reset gain 1.
// - Second gain register bits 6:4 hold the channel-5 gain code, reset 000b.
// - Second gain register bits 2:0 hold the channel-4 gain code.
// - Second gain register is at index 5 and resets to 0000h.
// - Configuration register is at index 6 and resets to 0600h.
// - Bits 12:9 set the chop settling delay of 2^(n+1) modulator periods.
// - Bit 8 enables global chopping, and is clear after reset.
// - Bit 7 makes detection need all channels instead of any channel.
// - First gain register is at index 4, resets to 0000h, holds channels 0 to 3.
// - Bits 6:4 select 2^n threshold exceedances to trigger a detection.
// - Bits 3:1 select the detect measurement length in conversion periods.
module adc_cfg_regs
  import adc_cfg_pkg::*;
#(
  parameter int CH = adc_cfg_pkg::NCH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [adc_cfg_pkg::ADDR_W-1:0] paddr,
  input wire logic [adc_cfg_pkg::DATA_W-1:0] pwdata,
  output logic [adc_cfg_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mod_tick,
  input wire logic chop_start,
  input wire logic [CH-1:0] ch_hit,
  output logic [adc_cfg_pkg::GAIN_W-1:0] ch0_gain_code,
  output logic [adc_cfg_pkg::GAIN_W-1:0] ch1_gain_code,
  output logic [adc_cfg_pkg::GAIN_W-1:0] ch4_gain_code,
  output logic [adc_cfg_pkg::GAIN_W-1:0] ch5_gain_code,
  output logic chop_enable,
  output logic [adc_cfg_pkg::DLY_W-1:0] chop_settle_delay,
  output logic measure_hold,
  output logic settle_done,
  output logic detect_enable,
  output logic detect_all_channels,
  output logic [2:0] detect_exceed_count,
  output logic [2:0] detect_measure_length,
  output logic [7:0] detect_exceed_threshold,
  output logic [11:0] detect_length_periods,
  output logic detect_trigger
);
  import adc_cfg_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [REG_W-1:0] gain_select_ch0_ch3;
    logic [REG_W-1:0] gain_select_ch4_ch5;
    logic [REG_W-1:0] cfg;
    logic [DATA_W-1:0] rdata;
    logic ready;
    logic err;
    logic trig;
    logic [7:0] thr;
    logic [11:0] len;
  } regs_s;

  regs_s state_reg;
  regs_s state_next;
  logic access;
  logic commit;
  logic hit_any;
  logic hit_all;
  logic timer_busy;
  logic timer_done;
  logic [REG_W-1:0] status_word;
  logic [2:0] len_code;
  logic [2:0] num_code;

  // An access phase takes two cycles: one wait, then pready with data.
  // The wait keeps read data registered without a combinational path.
  assign access = psel && penable;
  assign commit = access && state_reg.ready;

  assign hit_any = |ch_hit;
  assign hit_all = &ch_hit;
  assign len_code = state_reg.cfg[CFG_LEN_LSB +: 3];
  assign num_code = state_reg.cfg[CFG_NUM_LSB +: 3];

  // Live state that software can observe.
  always_comb begin
    status_word = '0;
    status_word[STAT_BUSY_BIT] = timer_busy;
    status_word[STAT_TRIG_BIT] = state_reg.trig;
  end

  // ----------------------------------------------------------------
  // Chop settling sequencer
  // ----------------------------------------------------------------
  // Starts are ignored while chop is off; turning chop off aborts a wait.
  settle_timer #(
    .CNT_W(CNT_W),
    .CODE_W(DLY_W)
  ) u_settle (
    .pclk(pclk),
    .presetn(presetn),
    .start(chop_start && state_reg.cfg[CFG_CHOP_BIT]),
    .abort(!state_reg.cfg[CFG_CHOP_BIT]),
    .tick(mod_tick),
    .code(state_reg.cfg[CFG_DLY_LSB +: DLY_W]),
    .busy(timer_busy),
    .done(timer_done)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Reserved bits are stored as written; software keeps them zero.
  // Unmapped addresses answer with pslverr and read zero.
  always_comb begin
    state_next = state_reg;
    state_next.ready = 1'b0;
    state_next.err = 1'b0;
    if (access && !state_reg.ready) begin
      state_next.ready = 1'b1;
      state_next.rdata = '0;
      if (paddr == ADDR_GAIN_SELECT_CH0_CH3) begin
        state_next.rdata[REG_W-1:0] = state_reg.gain_select_ch0_ch3;
      end else if (paddr == ADDR_GAIN_SELECT_CH4_CH5) begin
        state_next.rdata[REG_W-1:0] = state_reg.gain_select_ch4_ch5;
      end else if (paddr == ADDR_CFG) begin
        state_next.rdata[REG_W-1:0] = state_reg.cfg;
      end else if (paddr == ADDR_STATUS) begin
        state_next.rdata[REG_W-1:0] = status_word;
      end else begin
        state_next.err = 1'b1;
      end
    end
    if (commit && pwrite) begin
      if (paddr == ADDR_GAIN_SELECT_CH0_CH3) begin
        state_next.gain_select_ch0_ch3 = pwdata[REG_W-1:0];
      end else if (paddr == ADDR_GAIN_SELECT_CH4_CH5) begin
        state_next.gain_select_ch4_ch5 = pwdata[REG_W-1:0];
      end else if (paddr == ADDR_CFG) begin
        state_next.cfg = pwdata[REG_W-1:0];
      end
    end
    // Trigger is any-channel or all-channel by the select bit.
    state_next.trig = state_reg.cfg[CFG_DEN_BIT] &&
      (state_reg.cfg[CFG_ALL_BIT] ? hit_all : hit_any);
    state_next.thr = 8'h01 << num_code;
    state_next.len = LEN_TABLE[len_code];
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
      state_reg.gain_select_ch0_ch3 <= RST_GAIN;
      state_reg.gain_select_ch4_ch5 <= RST_GAIN;
      state_reg.cfg <= RST_CFG;
      state_reg.thr <= 8'h01;
      state_reg.len <= LEN_TABLE[0];
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output is a flop of the state or of the timer.
  assign prdata = state_reg.rdata;
  assign pready = state_reg.ready;
  assign pslverr = state_reg.err;
  assign ch0_gain_code = state_reg.gain_select_ch0_ch3[GAIN_LO_LSB +: GAIN_W];
  assign ch1_gain_code = state_reg.gain_select_ch0_ch3[GAIN_HI_LSB +: GAIN_W];
  assign ch4_gain_code = state_reg.gain_select_ch4_ch5[GAIN_LO_LSB +: GAIN_W];
  assign ch5_gain_code = state_reg.gain_select_ch4_ch5[GAIN_HI_LSB +: GAIN_W];
  assign chop_enable = state_reg.cfg[CFG_CHOP_BIT];
  assign chop_settle_delay = state_reg.cfg[CFG_DLY_LSB +: DLY_W];
  assign measure_hold = timer_busy;
  assign settle_done = timer_done;
  assign detect_enable = state_reg.cfg[CFG_DEN_BIT];
  assign detect_all_channels = state_reg.cfg[CFG_ALL_BIT];
  assign detect_exceed_count = num_code;
  assign detect_measure_length = len_code;
  assign detect_exceed_threshold = state_reg.thr;
  assign detect_length_periods = state_reg.len;
  assign detect_trigger = state_reg.trig;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Helper: ticks seen during one settling wait; a restart begins a new count,
  // since the timer itself restarts from zero on every accepted start.
  logic [CNT_W:0] tick_seen;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_seen <= '0;
    end else if (!timer_busy || (chop_start && chop_enable)) begin
      tick_seen <= '0;
    end else if (mod_tick) begin
      tick_seen <= tick_seen + (CNT_W+1)'(1);
    end
  end

  sequence s_write(logic [ADDR_W-1:0] a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence

  sequence s_request;
    psel && penable && !pready;
  endsequence

  property p_ch1_write;
    logic [2:0] v;
    (s_write(ADDR_GAIN_SELECT_CH0_CH3), v = pwdata[6:4]) |=> ch1_gain_code == v;
  endproperty
  a_ch1_write: assert property (p_ch1_write)
    else $error("channel 1 gain code not taken from write");

  property p_ch0_write;
    logic [2:0] v;
    (s_write(ADDR_GAIN_SELECT_CH0_CH3), v = pwdata[2:0]) |=> ch0_gain_code == v;
  endproperty
  a_ch0_write: assert property (p_ch0_write)
    else $error("channel 0 gain code not taken from write");

  property p_ch5_write;
    s_write(ADDR_GAIN_SELECT_CH4_CH5) |=> ch5_gain_code == $past(pwdata[6:4]);
  endproperty
  a_ch5_write: assert property (p_ch5_write)
    else $error("channel 5 gain code not taken from write");

  property p_ch4_write;
    s_write(ADDR_GAIN_SELECT_CH4_CH5) |=> ch4_gain_code == $past(pwdata[2:0]);
  endproperty
  a_ch4_write: assert property (p_ch4_write)
    else $error("channel 4 gain code not taken from write");

  property p_gain_select_ch4_ch5_reset;
    $rose(presetn) |-> ch4_gain_code == 3'h0 && ch5_gain_code == 3'h0;
  endproperty
  a_gain_select_ch4_ch5_reset: assert property (p_gain_select_ch4_ch5_reset)
    else $error("second gain register reset value wrong");

  property p_cfg_read;
    s_request ##1 (pready && !pwrite && paddr == ADDR_CFG)
      |-> prdata[REG_W-1:0] == state_reg.cfg && !pslverr;
  endproperty
  a_cfg_read: assert property (p_cfg_read)
    else $error("configuration readback wrong");

  property p_cfg_reset;
    $rose(presetn) |-> chop_settle_delay == 4'h3 && !chop_enable;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset)
    else $error("configuration reset value wrong");

  property p_settle_len;
    $fell(timer_busy) && $past(chop_enable) |->
      $past(tick_seen) + (CNT_W+1)'(1) ==
      ((CNT_W+1)'(1) << ($past(chop_settle_delay) + 5'd1));
  endproperty
  a_settle_len: assert property (p_settle_len)
    else $error("settling wait length wrong");

  property p_chop_off;
    !chop_enable |=> !measure_hold;
  endproperty
  a_chop_off: assert property (p_chop_off)
    else $error("settling wait while chop disabled");

  property p_chop_start;
    chop_start && chop_enable |=> measure_hold [*2] or
      (measure_hold ##1 settle_done);
  endproperty
  a_chop_start: assert property (p_chop_start)
    else $error("settling wait did not start");

  property p_trigger;
    ##1 detect_trigger == $past(detect_enable &&
      (detect_all_channels ? &ch_hit : |ch_hit));
  endproperty
  a_trigger: assert property (p_trigger)
    else $error("detect trigger combine wrong");

  property p_gain_select_ch0_ch3_reset;
    $rose(presetn) |-> state_reg.gain_select_ch0_ch3 == 16'h0000;
  endproperty
  a_gain_select_ch0_ch3_reset: assert property (p_gain_select_ch0_ch3_reset)
    else $error("first gain register reset value wrong");

  property p_threshold;
    ##1 detect_exceed_threshold == 8'h01 << $past(detect_exceed_count);
  endproperty
  a_threshold: assert property (p_threshold)
    else $error("exceedance count decode wrong");

  property p_length;
    ##1 $past(detect_measure_length) == 3'h7 |-> detect_length_periods == 12'hE00;
  endproperty
  a_length: assert property (p_length)
    else $error("measurement length decode wrong");

  property p_length_base;
    ##1 $past(detect_measure_length) == 3'h0 |-> detect_length_periods == 12'h080;
  endproperty
  a_length_base: assert property (p_length_base)
    else $error("shortest measurement length decode wrong");

  property p_done_pulse;
    settle_done |-> !measure_hold ##1 !settle_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("settle done not a single pulse ending the wait");

  property p_all_needs_every;
    detect_enable && detect_all_channels && !(&ch_hit) |=> !detect_trigger;
  endproperty
  a_all_needs_every: assert property (p_all_needs_every)
    else $error("all-channel trigger fired with a channel missing");

  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready held more than one cycle");

  property p_answer;
    psel && penable && !pready |=> pready;
  endproperty
  a_answer: assert property (p_answer)
    else $error("access not answered after one wait");

endmodule // adc_cfg_regs

// *** adc_gain_chop_detect_regs_tb.sv ***
/*
  Self-checking testbench for the gain, chop and detect register bank.
  Assumes the bank answers APB with one wait state and that every
  output named in the port list follows the stored fields.
*/
`timescale 1ns/1ps
module adc_gain_chop_detect_regs_tb;
  import adc_cfg_pkg::*;

  // ----------------------------------------------------------------
  // Signals and expected tables
  // ----------------------------------------------------------------
  localparam logic [7:0] A_G1 = 8'h10;
  localparam logic [7:0] A_G2 = 8'h14;
  localparam logic [7:0] A_CFG = 8'h18;
  localparam logic [7:0] A_STAT = 8'h80;
  localparam logic [7:0] A_NONE = 8'h40;
  localparam int LEN_EXP [8] = '{128, 256, 512, 768, 1280, 1792, 2560, 3584};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic mod_tick, chop_start, chop_enable, measure_hold, settle_done;
  logic [5:0] ch_hit;
  logic [2:0] ch0_gain_code, ch1_gain_code, ch4_gain_code, ch5_gain_code;
  logic [3:0] chop_settle_delay;
  logic detect_enable, detect_all_channels, detect_trigger;
  logic [2:0] detect_exceed_count, detect_measure_length;
  logic [7:0] detect_exceed_threshold;
  logic [11:0] detect_length_periods;
  int err_count = 0;
  int checks = 0;

  adc_cfg_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mod_tick(mod_tick), .chop_start(chop_start), .ch_hit(ch_hit),
    .ch0_gain_code(ch0_gain_code), .ch1_gain_code(ch1_gain_code),
    .ch4_gain_code(ch4_gain_code), .ch5_gain_code(ch5_gain_code),
    .chop_enable(chop_enable), .chop_settle_delay(chop_settle_delay),
    .measure_hold(measure_hold), .settle_done(settle_done), .detect_enable(detect_enable),
    .detect_all_channels(detect_all_channels), .detect_exceed_count(detect_exceed_count),
    .detect_measure_length(detect_measure_length),
    .detect_exceed_threshold(detect_exceed_threshold),
    .detect_length_periods(detect_length_periods), .detect_trigger(detect_trigger));

  // ----------------------------------------------------------------
  // Clock, reset and shared tasks
  // ----------------------------------------------------------------
  // The clock runs at 10 MHz.
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask

  // One APB transfer; the request holds until pready is seen at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Writes keep every reserved bit at zero.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    repeat (2) @(posedge pclk);
    #1;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, experr});
  endtask

  function automatic logic [31:0] cfg(input logic [3:0] dly, input logic ce, input logic all,
                                      input logic [2:0] num, input logic [2:0] len,
                                      input logic den);
    return {16'h0000, 3'b000, dly, ce, all, num, len, den};
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values();
    rdchk(A_G1, 32'h0000_0000, 1'b0);
    rdchk(A_G2, 32'h0000_0000, 1'b0);
    rdchk(A_CFG, 32'h0000_0600, 1'b0);
    chk({29'h0, ch1_gain_code}, 32'h0);
    chk({29'h0, ch0_gain_code}, 32'h0);
    chk({28'h0, chop_settle_delay}, 32'h3);
    chk({31'h0, chop_enable}, 32'h0);
    chk({31'h0, detect_all_channels}, 32'h0);
    chk({24'h0, detect_exceed_threshold}, 32'h1);
    chk({20'h0, detect_length_periods}, 32'd128);
  endtask

  // Each gain field takes every code while its neighbour takes the mirror code.
  task automatic t_gain_codes();
    logic [2:0] c;
    for (int n = 0; n < 8; n++) begin
      c = 3'(n);
      wr(A_G1, {25'h0, c, 1'b0, ~c});
      wr(A_G2, {25'h0, ~c, 1'b0, c});
      chk({29'h0, ch1_gain_code}, {29'h0, c});
      chk({29'h0, ch0_gain_code}, {29'h0, ~c});
      chk({29'h0, ch5_gain_code}, {29'h0, ~c});
      chk({29'h0, ch4_gain_code}, {29'h0, c});
      rdchk(A_G2, {25'h0, ~c, 1'b0, c}, 1'b0);
      rdchk(A_G1, {25'h0, c, 1'b0, ~c}, 1'b0);
    end
  endtask

  task automatic t_cfg_fields();
    logic [2:0] c;
    for (int n = 0; n < 8; n++) begin
      c = 3'(n);
      wr(A_CFG, cfg(4'(15 - n), c[0], c[1], c, ~c, c[2]));
      chk({28'h0, chop_settle_delay}, 32'(15 - n));
      chk({31'h0, chop_enable}, {31'h0, c[0]});
      chk({31'h0, detect_all_channels}, {31'h0, c[1]});
      chk({31'h0, detect_enable}, {31'h0, c[2]});
      chk({29'h0, detect_exceed_count}, {29'h0, c});
      chk({24'h0, detect_exceed_threshold}, 32'(1 << n));
      chk({29'h0, detect_measure_length}, {29'h0, ~c});
      chk({20'h0, detect_length_periods}, 32'(LEN_EXP[7 - n]));
      rdchk(A_CFG, cfg(4'(15 - n), c[0], c[1], c, ~c, c[2]), 1'b0);
    end
  endtask

  // Any-channel and all-channel trigger modes, and the disabled case.
  task automatic t_detect();
    logic all_t [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    logic den_t [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    logic [5:0] hit_t [5] = '{6'h04, 6'h00, 6'h1F, 6'h3F, 6'h3F};
    logic exp_t [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 5; i++) begin
      wr(A_CFG, cfg(4'h3, 1'b0, all_t[i], 3'h0, 3'h0, den_t[i]));
      @(posedge pclk);
      ch_hit <= hit_t[i];
      repeat (2) @(posedge pclk);
      #1;
      chk({31'h0, detect_trigger}, {31'h0, exp_t[i]});
      @(posedge pclk);
      ch_hit <= 6'h00;
    end
  endtask

  // Settling waits of 2 and 4 ticks; a start with chop disabled is ignored.
  task automatic t_settle();
    logic [31:0] r;
    logic e;
    wr(A_CFG, cfg(4'h0, 1'b0, 1'b0, 3'h0, 3'h0, 1'b0));
    @(posedge pclk);
    chop_start <= 1'b1;
    @(posedge pclk);
    chop_start <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    chk({31'h0, measure_hold}, 32'h0);
    for (int code = 0; code < 2; code++) begin
      wr(A_CFG, cfg(4'(code), 1'b1, 1'b0, 3'h0, 3'h0, 1'b0));
      @(posedge pclk);
      chop_start <= 1'b1;
      @(posedge pclk);
      chop_start <= 1'b0;
      #1;
      chk({31'h0, measure_hold}, 32'h1);
      apb(1'b0, A_STAT, 32'h0, r, e);
      chk({31'h0, r[0]}, 32'h1);
      for (int i = 0; i < (2 << code); i++) begin
        @(posedge pclk);
        mod_tick <= 1'b1;
        @(posedge pclk);
        mod_tick <= 1'b0;
        #1;
        chk({30'h0, measure_hold, settle_done}, (i < (2 << code) - 1) ? 32'h2 : 32'h1);
      end
      @(posedge pclk);
      #1;
      chk({30'h0, measure_hold, settle_done}, 32'h0);
    end
  endtask

  // An unmapped address is refused and reads as zero.
  task automatic t_unmapped();
    wr(A_NONE, 32'h0000_FFFF);
    rdchk(A_NONE, 32'h0, 1'b1);
    rdchk(A_CFG, cfg(4'h1, 1'b1, 1'b0, 3'h0, 3'h0, 1'b0), 1'b0);
  endtask

  // A reset in mid-run returns every register and output to its reset value.
  task automatic t_mid_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    chk({31'h0, chop_enable}, 32'h0);
    chk({29'h0, ch1_gain_code}, 32'h0);
    presetn <= 1'b1;
    t_reset_values();
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  // Reset is held for 16 cycles with every input quiet.
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    mod_tick = 1'b0;
    chop_start = 1'b0;
    ch_hit = 6'h00;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_values();
    t_gain_codes();
    t_cfg_fields();
    t_detect();
    t_settle();
    t_unmapped();
    t_mid_reset();
    end_of_test();
  end

  // The whole run needs a few hundred cycles; 20000 means a hang.
  initial begin
    #2000000;
    err_count++;
    end_of_test();
  end
endmodule // adc_gain_chop_detect_regs_tb
